// *** inc/rbs_cfg.svh ***
/*
 * Register map, field positions and sizes of the receive robbed-bit signaling block.
 * Assumes word-indexed registers: byte address = 4 * index.
 */
`ifndef RBS_CFG_SVH
`define RBS_CFG_SVH

`define RBS_AXI_AW        16
`define RBS_IDX_W         12
`define RBS_SLOT_W        5
`define RBS_N_SLOTS       24
`define RBS_IDX_CTRL      12'h100
`define RBS_IDX_SFCTRL    12'h107
`define RBS_IDX_SUBST     12'h3C0
`define RBS_IDX_ARRAY     12'h500
`define RBS_CTRL_EXT_LSB  0
`define RBS_CTRL_SUB_LSB  2
`define RBS_CTRL_DEB_BIT  4
`define RBS_SFCTRL_BIT    7
`define RBS_RESP_OKAY     2'h0
`define RBS_RESP_SLVERR   2'h2
`define RBS_MASK_NONE     4'h0
`define RBS_MASK_16       4'hF
`define RBS_MASK_4        4'hC
`define RBS_MASK_2        4'h8

`endif

// *** inc/rbs_pkg.sv ***
/*
 * Types shared by the receive robbed-bit signaling block.
 * Assumes rbs_cfg.svh is on the include path.
 */
`include "rbs_cfg.svh"

package rbs_pkg;

    typedef enum logic [1:0] {
        SIG_NONE,
        SIG_16,
        SIG_4,
        SIG_2
    } sig_mode_t;

    typedef struct packed {
        logic                      awvalid;
        logic [`RBS_AXI_AW-1:0]    awaddr;
        logic                      wvalid;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bready;
        logic                      arvalid;
        logic [`RBS_AXI_AW-1:0]    araddr;
        logic                      rready;
    } axil_req_t;

    typedef struct packed {
        logic                      awready;
        logic                      wready;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      arready;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic                      valid;
        logic [`RBS_SLOT_W-1:0]    slot;
        logic [3:0]                abcd;
        logic                      sf_boundary;
    } sig_sample_t;

endpackage

// *** design/axil_reg_slave.sv ***
/*
 * AXI4-Lite slave: takes address and data in either order, one write and one read at a time.
 * Assumes the parent decodes o_wr_addr/o_rd_addr combinationally into ok and read data.
 */
`timescale 1ns/100ps
`include "rbs_cfg.svh"

module axil_reg_slave (
    // Clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rstn,
    // Bus
    input  wire rbs_pkg::axil_req_t        i_req,
    output rbs_pkg::axil_rsp_t             o_rsp,
    // Register side
    input  wire logic                      i_wr_ok,
    input  wire logic                      i_rd_ok,
    input  wire logic [31:0]               i_rd_data,
    output logic                           o_wr_en,
    output logic [`RBS_AXI_AW-1:0]         o_wr_addr,
    output logic [31:0]                    o_wr_data,
    output logic [3:0]                     o_wr_strb,
    output logic [`RBS_AXI_AW-1:0]         o_rd_addr
);
    import rbs_pkg::*;

    typedef struct packed {
        logic                   awready;
        logic                   wready;
        logic                   arready;
        logic                   aw_have;
        logic                   w_have;
        logic                   ar_have;
        logic [`RBS_AXI_AW-1:0] awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic [`RBS_AXI_AW-1:0] araddr;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic                   wr_en;
    } slv_state_t;

    localparam slv_state_t ST_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1,
                                      default: '0};

    slv_state_t st;
    slv_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.wr_en = 1'b0;
        if (i_req.awvalid && st.awready) begin
            next_st.aw_have = 1'b1;
            next_st.awaddr  = i_req.awaddr;
            next_st.awready = 1'b0;
        end
        if (i_req.wvalid && st.wready) begin
            next_st.w_have = 1'b1;
            next_st.wdata  = i_req.wdata;
            next_st.wstrb  = i_req.wstrb;
            next_st.wready = 1'b0;
        end
        // Address stays stable until the response is taken, so the pulse sees it
        if (st.aw_have && st.w_have && !st.bvalid) begin
            next_st.aw_have = 1'b0;
            next_st.w_have  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = i_wr_ok ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
            next_st.wr_en   = i_wr_ok;
        end
        if (st.bvalid && i_req.bready) begin
            next_st.bvalid  = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready  = 1'b1;
        end
        if (i_req.arvalid && st.arready) begin
            next_st.ar_have = 1'b1;
            next_st.araddr  = i_req.araddr;
            next_st.arready = 1'b0;
        end
        if (st.ar_have) begin
            next_st.ar_have = 1'b0;
            next_st.rvalid  = 1'b1;
            next_st.rdata   = i_rd_ok ? i_rd_data : 32'h0000_0000;
            next_st.rresp   = i_rd_ok ? `RBS_RESP_OKAY : `RBS_RESP_SLVERR;
        end
        if (st.rvalid && i_req.rready) begin
            next_st.rvalid  = 1'b0;
            next_st.arready = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_rsp = '{awready: st.awready, wready: st.wready, bvalid: st.bvalid,
                     bresp: st.bresp, arready: st.arready, rvalid: st.rvalid,
                     rdata: st.rdata, rresp: st.rresp};
    assign o_wr_en   = st.wr_en;
    assign o_wr_addr = st.awaddr;
    assign o_wr_data = st.wdata;
    assign o_wr_strb = st.wstrb;
    assign o_rd_addr = st.araddr;

endmodule

// *** design/sig_slot_store.sv ***
/*
 * One timeslot's signaling entry with two-superframe debounce and boundary-aligned update.
 * Assumes at most one sample per superframe for this slot.
 */
`timescale 1ns/100ps

module sig_slot_store (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_rstn,
    // Sample and controls
    input  wire logic        i_hit,
    input  wire logic [3:0]  i_code,
    input  wire logic        i_debounce,
    input  wire logic        i_sf_align,
    input  wire logic        i_sf_boundary,
    // Stored state
    output logic [3:0]       o_state
);
    typedef struct packed {
        logic       have_last;
        logic [3:0] last;
        logic       staged_valid;
        logic [3:0] staged;
        logic [3:0] entry;
    } slot_state_t;

    slot_state_t st;
    slot_state_t next_st;
    logic        accept;

    always_comb begin
        next_st = st;
        accept  = 1'b0;
        if (i_sf_boundary && st.staged_valid) begin
            next_st.entry        = st.staged; // RULE12
            next_st.staged_valid = 1'b0;
        end
        if (i_hit) begin
            // Mismatch keeps the entry as is and only remembers the new sample
            accept = i_debounce ? (st.have_last && (i_code == st.last)) : 1'b1; // RULE10 RULE11
            next_st.last      = i_code;
            next_st.have_last = 1'b1;
            if (accept) begin
                if (i_debounce && i_sf_align) begin
                    next_st.staged       = i_code; // RULE12
                    next_st.staged_valid = 1'b1;
                end else begin
                    next_st.entry = i_code; // RULE13
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_state = st.entry;

endmodule

// *** design/rx_robbed_bit_signaling.sv ***
/*
 * Receive robbed-bit signaling: extraction, substitution and per-timeslot state array.
 * Assumes framer logic on i_clk_sys presents one decoded A,B,C,D sample per timeslot per
 * superframe, and a one-cycle superframe boundary pulse; registers over AXI4-Lite.
 */
// Function
// RULE1: Extraction mode none stores no signaling from received timeslots.
// RULE2: Sixteen-state mode extracts A, B, C and D.
// RULE3: Four-state mode extracts only A and B.
// RULE4: Two-state mode extracts only A.
// RULE5: Any substitution mode replaces A with substitute bit 3.
// RULE6: Sixteen- or four-state substitution replaces B with substitute bit 2.
// RULE7: Only sixteen-state substitution replaces C with substitute bit 1.
// RULE8: Only sixteen-state substitution replaces D with substitute bit 0.
// RULE9: Read-only entry per timeslot holds latest A,B,C,D in bits 3..0.
// RULE10: With debounce, update only after two consecutive superframes agree.
// RULE11: With debounce, differing consecutive superframes leave the entry unchanged.
// RULE12: Debounce on and superframe-update bit set: array written only at superframe boundaries.
// RULE13: Debounce off or update bit clear: entry updated as soon as received.
// RULE14: Software trusts array contents only while robbed-bit signaling is enabled.
// RULE15: Substitute entry n and array entry n belong to timeslot n.
`timescale 1ns/100ps
`include "rbs_cfg.svh"

module rx_robbed_bit_signaling #(
    parameter int N_SLOTS = `RBS_N_SLOTS
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    // Received signaling from the framer
    input  wire rbs_pkg::sig_sample_t  i_sig,
    // Register bus
    input  wire rbs_pkg::axil_req_t    i_axi,
    output rbs_pkg::axil_rsp_t         o_axi
);
    import rbs_pkg::*;

    typedef struct packed {
        sig_mode_t                    ext_mode;
        sig_mode_t                    sub_mode;
        logic                         debounce;
        logic                         sf_align;
        logic [N_SLOTS-1:0][3:0]      subst;
        logic                         smp_valid;
        logic [`RBS_SLOT_W-1:0]       smp_slot;
        logic [3:0]                   smp_code;
        logic                         smp_sf;
    } top_state_t;

    top_state_t                   st;
    top_state_t                   next_st;

    logic                         wr_en;
    logic [`RBS_AXI_AW-1:0]       wr_addr;
    logic [31:0]                  wr_data;
    logic [3:0]                   wr_strb;
    logic [`RBS_AXI_AW-1:0]       rd_addr;
    logic                         wr_ok;
    logic                         rd_ok;
    logic [31:0]                  rd_data;
    logic [N_SLOTS-1:0][3:0]      array;
    logic [`RBS_IDX_W-1:0]        wr_idx;
    logic [`RBS_IDX_W-1:0]        rd_idx;
    logic [`RBS_IDX_W-1:0]        wr_sub_off;
    logic [`RBS_IDX_W-1:0]        rd_sub_off;
    logic [`RBS_IDX_W-1:0]        rd_arr_off;
    logic [3:0]                   ext_mask;
    logic [3:0]                   sub_mask;
    logic [3:0]                   raw;

    // Register decode
    assign wr_idx     = wr_addr[`RBS_IDX_W+1:2];
    assign rd_idx     = rd_addr[`RBS_IDX_W+1:2];
    assign wr_sub_off = wr_idx - `RBS_IDX_SUBST;
    assign rd_sub_off = rd_idx - `RBS_IDX_SUBST;
    assign rd_arr_off = rd_idx - `RBS_IDX_ARRAY;

    // Array is read-only, so a write to it answers with an error
    assign wr_ok = (wr_idx == `RBS_IDX_CTRL) || (wr_idx == `RBS_IDX_SFCTRL)
                || (wr_sub_off < `RBS_IDX_W'(N_SLOTS));

    function automatic logic [3:0] mode_mask(input sig_mode_t m);
        logic [3:0] mk;
        case (m)
            SIG_16:  mk = `RBS_MASK_16;
            SIG_4:   mk = `RBS_MASK_4;
            SIG_2:   mk = `RBS_MASK_2;
            default: mk = `RBS_MASK_NONE;
        endcase
        return mk;
    endfunction

    always_comb begin
        rd_ok   = 1'b1;
        rd_data = 32'h0000_0000;
        if (rd_idx == `RBS_IDX_CTRL) begin
            rd_data[`RBS_CTRL_EXT_LSB +: 2] = st.ext_mode;
            rd_data[`RBS_CTRL_SUB_LSB +: 2] = st.sub_mode;
            rd_data[`RBS_CTRL_DEB_BIT]      = st.debounce;
        end else if (rd_idx == `RBS_IDX_SFCTRL) begin
            rd_data[`RBS_SFCTRL_BIT] = st.sf_align;
        end else if (rd_sub_off < `RBS_IDX_W'(N_SLOTS)) begin
            rd_data[3:0] = st.subst[rd_sub_off]; // RULE15
        end else if (rd_arr_off < `RBS_IDX_W'(N_SLOTS)) begin
            rd_data[3:0] = array[rd_arr_off]; // RULE9 RULE15
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Extraction and substitution masks
    always_comb begin
        ext_mask = mode_mask(st.ext_mode); // RULE2 RULE3 RULE4
        sub_mask = mode_mask(st.sub_mode); // RULE5 RULE6 RULE7 RULE8
        raw      = i_sig.abcd;
    end

    always_comb begin
        next_st = st;
        if (wr_en && wr_strb[0]) begin
            if (wr_idx == `RBS_IDX_CTRL) begin
                next_st.ext_mode = sig_mode_t'(wr_data[`RBS_CTRL_EXT_LSB +: 2]);
                next_st.sub_mode = sig_mode_t'(wr_data[`RBS_CTRL_SUB_LSB +: 2]);
                next_st.debounce = wr_data[`RBS_CTRL_DEB_BIT];
            end else if (wr_idx == `RBS_IDX_SFCTRL) begin
                next_st.sf_align = wr_data[`RBS_SFCTRL_BIT];
            end else if (wr_sub_off < `RBS_IDX_W'(N_SLOTS)) begin
                next_st.subst[wr_sub_off] = wr_data[3:0]; // RULE15
            end
        end
        // Mode none drops the sample before it reaches the array
        next_st.smp_valid = i_sig.valid && (st.ext_mode != SIG_NONE) // RULE1
                         && (i_sig.slot < `RBS_SLOT_W'(N_SLOTS));
        next_st.smp_slot  = i_sig.slot;
        next_st.smp_sf    = i_sig.sf_boundary;
        next_st.smp_code  = 4'h0;
        if (i_sig.slot < `RBS_SLOT_W'(N_SLOTS)) begin
            // Substituted bits still pass the extraction mask, unextracted bits read zero
            next_st.smp_code = ((raw & ~sub_mask) | (st.subst[i_sig.slot] & sub_mask))
                             & ext_mask; // RULE5 RULE6 RULE7 RULE8 RULE2 RULE3 RULE4
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    axil_reg_slave u_slave (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_req     (i_axi),
        .o_rsp     (o_axi),
        .i_wr_ok   (wr_ok),
        .i_rd_ok   (rd_ok),
        .i_rd_data (rd_data),
        .o_wr_en   (wr_en),
        .o_wr_addr (wr_addr),
        .o_wr_data (wr_data),
        .o_wr_strb (wr_strb),
        .o_rd_addr (rd_addr)
    );

    // One store per timeslot, sample n lands in entry n
    for (genvar n = 0; n < N_SLOTS; n++) begin : g_slot
        sig_slot_store u_store (
            .i_clk_sys     (i_clk_sys),
            .i_rstn        (i_rstn),
            .i_hit         (st.smp_valid && (st.smp_slot == `RBS_SLOT_W'(n))), // RULE15
            .i_code        (st.smp_code),
            .i_debounce    (st.debounce),
            .i_sf_align    (st.sf_align),
            .i_sf_boundary (st.smp_sf),
            .o_state       (array[n])
        );
    end

endmodule

// *** verification/rbs_properties.sv ***
/*
 * Checker: bus handshake timing and register-map properties of the signaling block.
 * Assumes binding to rx_robbed_bit_signaling; write address and data are offered together.
 */
`timescale 1ns/100ps
`include "rbs_cfg.svh"

module rbs_properties #(
    parameter int N_SLOTS = 24
) (
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    // Watched ports
    input  wire rbs_pkg::sig_sample_t  i_sig,
    input  wire rbs_pkg::axil_req_t    i_axi,
    input  wire rbs_pkg::axil_rsp_t    o_axi
);
    import rbs_pkg::*;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    logic wr_go;
    logic ro_hit;
    logic sub_hit;

    assign wr_go   = i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready;
    assign ro_hit  = (i_axi.awaddr[13:2] >= `RBS_IDX_ARRAY)
                  && (i_axi.awaddr[13:2] < `RBS_IDX_ARRAY + N_SLOTS);
    assign sub_hit = (i_axi.awaddr[13:2] >= `RBS_IDX_SUBST)
                  && (i_axi.awaddr[13:2] < `RBS_IDX_SUBST + N_SLOTS);

    a_ro_refused: assert property (wr_go && ro_hit |-> ##2 o_axi.bvalid
        && o_axi.bresp == `RBS_RESP_SLVERR) else $error("array write not refused");
    a_subst_taken: assert property (wr_go && sub_hit |-> ##2 o_axi.bvalid
        && o_axi.bresp == `RBS_RESP_OKAY) else $error("substitute write refused");
    a_resv_zero: assert property (o_axi.rvalid |-> o_axi.rdata[31:4] == 28'h0)
        else $error("reserved read bits not zero");
    a_rd_latency: assert property (i_axi.arvalid && o_axi.arready |-> ##2 o_axi.rvalid)
        else $error("read answer late");
    a_wr_latency: assert property (wr_go |=> !o_axi.bvalid ##1 o_axi.bvalid)
        else $error("write answer timing wrong");
    a_rd_hold: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid
        && $stable(o_axi.rdata)) else $error("read data dropped early");
    a_wr_hold: assert property (o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid
        && $stable(o_axi.bresp)) else $error("write response dropped early");
    a_ar_busy: assert property (i_axi.arvalid && o_axi.arready |=> !o_axi.arready
        until_with o_axi.rvalid) else $error("second read accepted");
    a_b_done: assert property (o_axi.bvalid && i_axi.bready |=> !o_axi.bvalid
        && o_axi.awready) else $error("write response not closed");
endmodule

bind rx_robbed_bit_signaling rbs_properties #(
    .N_SLOTS (N_SLOTS)
) i_rbs_properties (
    .i_clk_sys (i_clk_sys),
    .i_rstn    (i_rstn),
    .i_sig     (i_sig),
    .i_axi     (i_axi),
    .o_axi     (o_axi)
);

// *** verification/sig_line_model.sv ***
/*
 * Receive line model: delivers decoded signaling samples and superframe boundaries.
 * Assumes the bench calls send() from one process only.
 */
`timescale 1ns/100ps

module sig_line_model (
    // Clock
    input  wire logic            i_clk_sys,
    // Sample out
    output rbs_pkg::sig_sample_t o_sig
);
    import rbs_pkg::*;

    initial o_sig = '0;

    task automatic send(input logic v, input logic [4:0] s, input logic [3:0] c, input logic sf);
        @(posedge i_clk_sys);
        o_sig <= '{valid: v, slot: s, abcd: c, sf_boundary: sf};
        @(posedge i_clk_sys);
        // Idle line shows the inverse, so a stale sample cannot pass
        o_sig <= '{valid: 1'b0, slot: ~s, abcd: ~c, sf_boundary: 1'b0};
        repeat (3) @(posedge i_clk_sys);
    endtask
endmodule

// *** verification/testbench.sv ***
/*
 * Self-checking bench: register access, extraction and substitution modes, debounce, alignment.
 * Assumes the bind of rbs_properties and the sig_line_model partner.
 */
`timescale 1ns/100ps
`include "rbs_cfg.svh"

module testbench;
    import rbs_pkg::*;

    localparam logic [15:0] A_CTRL = {2'b00, `RBS_IDX_CTRL, 2'b00};
    localparam logic [15:0] A_SF   = {2'b00, `RBS_IDX_SFCTRL, 2'b00};
    localparam logic [15:0] A_SUB  = {2'b00, `RBS_IDX_SUBST, 2'b00};
    localparam logic [15:0] A_ARR  = {2'b00, `RBS_IDX_ARRAY, 2'b00};
    localparam logic [1:0]  OK     = 2'h0;
    localparam logic [1:0]  ERR    = 2'h2;

    logic        clk;
    logic        rstn;
    axil_req_t   ax;
    axil_rsp_t   rsp;
    sig_sample_t sig;
    int          n_mismatch;
    int          cmp_count;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    rx_robbed_bit_signaling #(.N_SLOTS(24)) i_rx_robbed_bit_signaling (
        .i_clk_sys (clk),
        .i_rstn    (rstn),
        .i_sig     (sig),
        .i_axi     (ax),
        .o_axi     (rsp)
    );

    sig_line_model i_sig_line_model (.i_clk_sys(clk), .o_sig(sig));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        @(posedge clk);
        ax.awvalid <= 1'b1;
        ax.awaddr  <= a;
        ax.wvalid  <= 1'b1;
        ax.wdata   <= d;
        ax.wstrb   <= 4'hF;
        ax.bready  <= 1'b1;
        pa = 1'b1;
        pw = 1'b1;
        while (pa || pw) begin
            @(posedge clk);
            if (pa && rsp.awready) begin
                ax.awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (pw && rsp.wready) begin
                ax.wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        while (rsp.bvalid !== 1'b1) @(posedge clk);
        chk(rsp.bresp, er);
        ax.bready <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        ax.arvalid <= 1'b1;
        ax.araddr  <= a;
        ax.rready  <= 1'b1;
        do @(posedge clk); while (rsp.arready !== 1'b1);
        ax.arvalid <= 1'b0;
        while (rsp.rvalid !== 1'b1) @(posedge clk);
        chk(rsp.rdata, ed);
        chk(rsp.rresp, er);
        ax.rready <= 1'b0;
    endtask

    function automatic logic [3:0] msk(input logic [1:0] m);
        case (m)
            2'd1: return 4'hF;
            2'd2: return 4'hC;
            2'd3: return 4'h8;
            default: return 4'h0;
        endcase
    endfunction

    function automatic logic [31:0] code(input logic [1:0] e, input logic [1:0] s,
                                         input logic [3:0] c, input logic [3:0] v);
        return {28'h0, ((c & ~msk(s)) | (v & msk(s))) & msk(e)};
    endfunction

    task automatic final_report;
        $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        ax = '0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rd(A_CTRL, 32'h0, OK);
        rd(A_SUB, 32'h0, OK);
        rd(A_ARR + 16'd92, 32'h0, OK);
        wr(A_SUB + 16'd20, 32'hFF, OK);
        rd(A_SUB + 16'd20, 32'hF, OK);
        wr(A_ARR, 32'h5, ERR);
        rd(16'h0004, 32'h0, ERR);
        $display("Test registers done");
        // Each mode pair on its own slot: array keeps old values on mode change
        for (int i = 0; i < 16; i++) begin
            wr(A_SUB + 16'(i * 4), 32'h5, OK);
            wr(A_CTRL, 32'(i), OK);
            i_sig_line_model.send(1'b1, 5'(i), 4'hA, 1'b0);
            rd(A_ARR + 16'(i * 4), code(2'(i), 2'(i >> 2), 4'hA, 4'h5), OK);
        end
        rd(A_ARR + 16'd64, 32'h0, OK);
        $display("Test modes done");
        wr(A_CTRL, 32'h11, OK);
        i_sig_line_model.send(1'b1, 5'd20, 4'h3, 1'b0);
        rd(A_ARR + 16'd80, 32'h0, OK);
        i_sig_line_model.send(1'b1, 5'd20, 4'h3, 1'b0);
        rd(A_ARR + 16'd80, 32'h3, OK);
        i_sig_line_model.send(1'b1, 5'd20, 4'h6, 1'b0);
        rd(A_ARR + 16'd80, 32'h3, OK);
        $display("Test debounce done");
        wr(A_SF, 32'h80, OK);
        i_sig_line_model.send(1'b1, 5'd21, 4'h5, 1'b0);
        i_sig_line_model.send(1'b1, 5'd21, 4'h5, 1'b0);
        rd(A_ARR + 16'd84, 32'h0, OK);
        i_sig_line_model.send(1'b0, 5'd0, 4'h0, 1'b1);
        rd(A_ARR + 16'd84, 32'h5, OK);
        wr(A_CTRL, 32'h01, OK);
        i_sig_line_model.send(1'b1, 5'd22, 4'h9, 1'b0);
        rd(A_ARR + 16'd88, 32'h9, OK);
        // Mode none must leave the stored entry alone, not overwrite it with zero
        wr(A_CTRL, 32'h00, OK);
        i_sig_line_model.send(1'b1, 5'd22, 4'h6, 1'b0);
        rd(A_ARR + 16'd88, 32'h9, OK);
        $display("Test alignment done");
        final_report();
    end

    // Whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule
